// File: shared/ots_consts.svh
// constants for the one-step time stamp pipeline
`ifndef OTS_CONSTS_SVH
`define OTS_CONSTS_SVH
// clock period in ns, also the local time step per edge
`define OTS_CLK_NS 30'h19
`define OTS_NS_PER_SEC 30'h3B9ACA00
// message types
`define OTS_MSG_SYNC 4'h0
`define OTS_MSG_DREQ 4'h1
// field offsets from the start of the ptp header
`define OTS_OFF_MSG 11'h000
`define OTS_OFF_DOM 11'h004
`define OTS_OFF_CF 11'h008
`define OTS_OFF_CF_END 11'h00F
`define OTS_OFF_RSV 11'h010
`define OTS_OFF_RSV_END 11'h013
`define OTS_OFF_ORG 11'h022
`define OTS_OFF_ORG_END 11'h02B
// udp checksum sits two bytes before the ptp header
`define OTS_OFF_UDP_HI 11'h7FE
`define OTS_OFF_UDP_LO 11'h7FF
// crc-32 reflected polynomial, seed and good-frame residue
`define OTS_CRC_POLY 32'hEDB88320
`define OTS_CRC_SEED 32'hFFFFFFFF
`define OTS_CRC_RES 32'hDEBB20E3
// default delay line depth and stamp fifo depth
`define OTS_DLY_DEF 16
`define OTS_TSF_DEF 8
`endif

// File: shared/ots_pkg.sv
// types for the one-step time stamp pipeline
package ots_pkg;
  // one byte of the frame stream
  typedef struct packed {
    logic vld;
    logic sof;
    logic eof;
    logic [7:0] data;
  } ots_beat_s;
  // seconds and nanoseconds of local time
  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } ots_time_s;
  // analyzer decision for the current frame
  typedef enum logic [1:0] {ignore_action, write_action, write_save_action} ots_act_e;
endpackage

// File: core/ots_pipe.sv
// one-step time stamp pipeline for one port and one direction
`include "ots_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module ots_pipe #(
  parameter int DLY = `OTS_DLY_DEF,
  parameter int TSF_DEPTH = `OTS_TSF_DEF
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic dir_egress, // 0 ingress, 1 egress
  input wire logic res_mode, // residence time for delay_req on egress
  input wire logic [7:0] domain_cfg,
  input wire logic [7:0] ptp_off, // ptp header start in frame
  input wire logic encap_v4,
  input wire logic encap_v6,
  input wire logic [7:0] pad_off, // ipv6 pad bytes, from ptp start
  input wire logic [29:0] lat_corr,
  input wire logic [63:0] asym, // scaled ns, as the correction field
  input wire logic [95:0] id_off, // 16 x 6-bit id byte offsets
  input wire ots_pkg::ots_beat_s in_beat, // clear-text side
  output var ots_pkg::ots_beat_s out_beat,
  output var ots_pkg::ots_time_s local_time,
  input wire logic ts_rd,
  output var logic ts_rd_vld,
  output var logic [127:0] ts_rd_id,
  output var ots_pkg::ots_time_s ts_rd_stamp,
  output var logic ts_empty,
  output var logic [$clog2(TSF_DEPTH):0] ts_level,
  output var logic ts_drop
);
  localparam int AW = $clog2(TSF_DEPTH);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // analyzer needs the reserved bytes in before the cf leaves
  if (DLY < 12 || TSF_DEPTH < 2 || (TSF_DEPTH & (TSF_DEPTH - 1)) != 0) begin : g_chk
    $error("ots_pipe: DLY below 12 or TSF_DEPTH not a power of two");
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one byte of reflected crc-32
  function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `OTS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  // ones' complement 16-bit add
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction
  // ----------------------------------------
  // local time
  // ----------------------------------------
  // ns counter wraps into the seconds counter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      local_time <= '0;
    end else if (local_time.ns >= `OTS_NS_PER_SEC - `OTS_CLK_NS) begin
      local_time.ns <= local_time.ns + `OTS_CLK_NS - `OTS_NS_PER_SEC;
      local_time.sec <= local_time.sec + 32'h00000001;
    end else begin
      local_time.ns <= local_time.ns + `OTS_CLK_NS;
    end
  end
  // ----------------------------------------
  // input side: position, stamp, analyzer
  // ----------------------------------------
  logic [10:0] pos_i_r; // byte index of last input byte
  logic [10:0] cur_i; // byte index of this input byte
  logic [10:0] rel_i; // index from ptp header start
  ots_pkg::ots_time_s adj; // corrected stamp of this instant
  logic [30:0] ns_sum; // egress ns plus latency
  assign cur_i = in_beat.sof ? 11'h000 : pos_i_r + 11'h001;
  assign rel_i = cur_i - {3'h0, ptp_off};
  assign ns_sum = {1'b0, local_time.ns} + {1'b0, lat_corr};
  // latency correction, borrowing or carrying a second
  always_comb begin
    adj = local_time;
    if (dir_egress) begin
      // egress adds latency
      if (ns_sum >= {1'b0, `OTS_NS_PER_SEC}) begin
        adj.ns = 30'(ns_sum - {1'b0, `OTS_NS_PER_SEC});
        adj.sec = local_time.sec + 32'h00000001;
      end else begin
        adj.ns = ns_sum[29:0];
      end
    end else if (local_time.ns >= lat_corr) begin
      adj.ns = local_time.ns - lat_corr;
    end else begin
      adj.ns = local_time.ns + `OTS_NS_PER_SEC - lat_corr;
      adj.sec = local_time.sec - 32'h00000001;
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pos_i_r <= 11'h000;
    end else if (in_beat.vld) begin
      pos_i_r <= cur_i;
    end
  end
  ots_pkg::ots_time_s stamp_r; // stamp of the frame in flight
  logic stamp_vld_r;
  ots_pkg::ots_act_e act_r; // analyzer decision
  logic [3:0] msg_r; // message type
  // stamp capture and analyzer decision
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stamp_r <= '0;
      stamp_vld_r <= 1'b0;
      act_r <= ots_pkg::ignore_action;
      msg_r <= 4'h0;
    end else if (in_beat.vld && in_beat.sof) begin
      stamp_r <= adj;
      stamp_vld_r <= 1'b1;
      act_r <= ots_pkg::ignore_action;
    end else if (in_beat.vld && rel_i == `OTS_OFF_MSG) begin
      msg_r <= in_beat.data[3:0];
    end else if (in_beat.vld && rel_i == `OTS_OFF_DOM) begin
      if (in_beat.data == domain_cfg && msg_r == `OTS_MSG_SYNC) begin
        act_r <= ots_pkg::write_action;
      end else if (in_beat.data == domain_cfg && msg_r == `OTS_MSG_DREQ) begin
        act_r <= dir_egress ? ots_pkg::write_save_action : ots_pkg::write_action;
      end else begin
        // delay_resp and other traffic end here
        act_r <= ots_pkg::ignore_action;
        stamp_vld_r <= 1'b0;
      end
    end
  end
  logic [63:0] cf_orig_r; // incoming correction field
  logic [31:0] rsv_orig_r; // incoming reserved bytes
  logic [15:0] pad_orig_r; // incoming ipv6 pad bytes
  logic [127:0] id_r; // frame identifier
  // copies of the fields the rewriter and the stamp fifo need
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cf_orig_r <= '0;
      rsv_orig_r <= '0;
      pad_orig_r <= '0;
      id_r <= '0;
    end else if (in_beat.vld) begin
      if (rel_i >= `OTS_OFF_CF && rel_i <= `OTS_OFF_CF_END) begin
        cf_orig_r <= {cf_orig_r[55:0], in_beat.data};
      end
      if (rel_i >= `OTS_OFF_RSV && rel_i <= `OTS_OFF_RSV_END) begin
        rsv_orig_r <= {rsv_orig_r[23:0], in_beat.data};
      end
      if (rel_i == {3'h0, pad_off}) begin
        pad_orig_r[15:8] <= in_beat.data;
      end
      if (rel_i == {3'h0, pad_off} + 11'h001) begin
        pad_orig_r[7:0] <= in_beat.data;
      end
      // id byte i taken from its configured offset
      for (int i = 0; i < 16; i++) begin
        if (rel_i == {5'h00, id_off[6*i +: 6]}) begin
          id_r[8*(15-i) +: 8] <= in_beat.data;
        end
      end
    end
  end
  logic [31:0] crc_i_r; // crc over incoming bytes
  logic [31:0] crc_i_nxt;
  logic fcs_bad_r; // incoming fcs was wrong
  assign crc_i_nxt = crc_b(in_beat.sof ? `OTS_CRC_SEED : crc_i_r, in_beat.data);
  // incoming fcs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      crc_i_r <= `OTS_CRC_SEED;
      fcs_bad_r <= 1'b0;
    end else if (in_beat.vld) begin
      crc_i_r <= crc_i_nxt;
      if (in_beat.eof) begin
        fcs_bad_r <= crc_i_nxt != `OTS_CRC_RES;
      end
    end
  end
  // ----------------------------------------
  // delay line
  // ----------------------------------------
  ots_pkg::ots_beat_s line [DLY];
  // fixed-length shift, copy goes to the analyzer above
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DLY; i++) begin
        line[i] <= '0;
      end
    end else begin
      line[0] <= in_beat;
      for (int i = 1; i < DLY; i++) begin
        line[i] <= line[i-1];
      end
    end
  end
  // ----------------------------------------
  // rewriter
  // ----------------------------------------
  ots_pkg::ots_beat_s st; // byte leaving the delay line
  logic [10:0] pos_o_r;
  logic [10:0] cur_o;
  logic [10:0] rel_o;
  logic tail_hit; // byte is one of the four fcs bytes
  logic [1:0] tail_idx;
  logic mod, asym_on, res_on, cf_mod;
  logic [29:0] resid; // departure minus software sub-second
  logic [63:0] cf_new;
  logic [79:0] org; // ten-byte origin stamp
  logic [31:0] crc_o_r;
  logic [31:0] fcs_out;
  logic [15:0] old_acc_r, new_acc_r, pad_new;
  logic [7:0] d; // byte sent
  logic chg; // byte changed, counted for ipv6 pad
  logic [31:0] rsv_new; // reserved-byte image of the stamp
  assign st = line[DLY-1];
  assign cur_o = st.sof ? 11'h000 : pos_o_r + 11'h001;
  assign rel_o = cur_o - {3'h0, ptp_off};
  assign mod = act_r != ots_pkg::ignore_action && stamp_vld_r;
  assign asym_on = dir_egress ? (msg_r == `OTS_MSG_DREQ) : (msg_r == `OTS_MSG_SYNC);
  assign res_on = dir_egress && res_mode && msg_r == `OTS_MSG_DREQ;
  assign cf_mod = asym_on || res_on;
  assign resid = stamp_r.ns >= rsv_orig_r[29:0] ? stamp_r.ns - rsv_orig_r[29:0]
               : stamp_r.ns + `OTS_NS_PER_SEC - rsv_orig_r[29:0];
  assign cf_new = cf_orig_r + (asym_on ? asym : 64'h0)
                + (res_on ? {18'h00000, resid, 16'h0000} : 64'h0);
  assign org = {16'h0000, stamp_r.sec, 2'b00, stamp_r.ns};
  assign rsv_new = {2'b00, stamp_r.ns};
  assign fcs_out = fcs_bad_r ? crc_o_r : ~crc_o_r;
  assign pad_new = oc_add(oc_add(pad_orig_r, old_acc_r), ~new_acc_r);
  // nearest end of frame tells which fcs byte this is
  always_comb begin
    tail_hit = 1'b0;
    tail_idx = 2'b00;
    for (int j = 3; j >= 0; j--) begin
      if (line[DLY-1-j].eof) begin
        tail_hit = 1'b1;
        tail_idx = 2'(3 - j);
      end
    end
  end
  // byte overwrite by position
  always_comb begin
    d = st.data;
    chg = 1'b0;
    if (mod) begin
      if (!dir_egress && rel_o >= `OTS_OFF_RSV && rel_o <= `OTS_OFF_RSV_END) begin
        d = rsv_new[8*(3-int'(rel_o[1:0])) +: 8];
        chg = 1'b1;
      end else if (cf_mod && rel_o >= `OTS_OFF_CF && rel_o <= `OTS_OFF_CF_END) begin
        d = cf_new[8*(7-int'(rel_o[2:0])) +: 8];
        chg = 1'b1;
      end else if (dir_egress && !res_on && rel_o >= `OTS_OFF_ORG
                   && rel_o <= `OTS_OFF_ORG_END) begin
        d = org[8*(9-int'(rel_o - `OTS_OFF_ORG)) +: 8];
        chg = 1'b1;
      end else if (encap_v4 && (rel_o == `OTS_OFF_UDP_HI || rel_o == `OTS_OFF_UDP_LO)) begin
        d = 8'h00;
      end else if (encap_v6 && rel_o == {3'h0, pad_off}) begin
        d = pad_new[15:8];
      end else if (encap_v6 && rel_o == {3'h0, pad_off} + 11'h001) begin
        d = pad_new[7:0];
      end
      if (tail_hit) begin
        d = fcs_out[8*int'(tail_idx) +: 8];
        chg = 1'b0;
      end
    end
  end
  // output register, crc and ipv6 change sums
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_beat <= '0;
      pos_o_r <= 11'h000;
      crc_o_r <= `OTS_CRC_SEED;
      old_acc_r <= 16'h0000;
      new_acc_r <= 16'h0000;
    end else begin
      out_beat <= '{vld: st.vld, sof: st.sof, eof: st.eof, data: d};
      if (st.vld) begin
        pos_o_r <= cur_o;
        if (!tail_hit) begin
          crc_o_r <= crc_b(st.sof ? `OTS_CRC_SEED : crc_o_r, d);
        end
        if (st.sof) begin
          old_acc_r <= 16'h0000;
          new_acc_r <= 16'h0000;
        end else if (chg) begin
          // track what changed for the pad fix
          old_acc_r <= oc_add(old_acc_r, cur_o[0] ? {8'h00, st.data} : {st.data, 8'h00});
          new_acc_r <= oc_add(new_acc_r, cur_o[0] ? {8'h00, d} : {d, 8'h00});
        end
      end
    end
  end
  // ----------------------------------------
  // transmit stamp fifo
  // ----------------------------------------
  typedef struct packed {
    logic [127:0] id;
    ots_pkg::ots_time_s ts;
  } ots_set_s;
  ots_set_s mem [TSF_DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic push, full;
  assign push = in_beat.vld && in_beat.eof && act_r == ots_pkg::write_save_action
              && stamp_vld_r;
  assign ts_level = wp_r - rp_r;
  assign full = ts_level == (AW+1)'(TSF_DEPTH);
  assign ts_empty = wp_r == rp_r;
  // store id with stamp, read one set per request
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
      ts_rd_vld <= 1'b0;
      ts_rd_id <= '0;
      ts_rd_stamp <= '0;
      ts_drop <= 1'b0;
    end else begin
      ts_drop <= push && full;
      if (push && !full) begin
        mem[wp_r[AW-1:0]] <= '{id: id_r, ts: stamp_r};
        wp_r <= wp_r + 1'b1;
      end
      ts_rd_vld <= ts_rd && !ts_empty;
      if (ts_rd && !ts_empty) begin
        ts_rd_id <= mem[rp_r[AW-1:0]].id;
        ts_rd_stamp <= mem[rp_r[AW-1:0]].ts;
        rp_r <= rp_r + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  stamp_capture_a: assert property (in_beat.vld && in_beat.sof && !dir_egress
    |=> stamp_r.ns == ($past(local_time.ns) >= $past(lat_corr)
        ? $past(local_time.ns) - $past(lat_corr)
        : $past(local_time.ns) + `OTS_NS_PER_SEC - $past(lat_corr)))
    else $error("ingress stamp not time minus latency");
  fixed_delay_a: assert property (##(DLY+1) out_beat.vld == $past(in_beat.vld, DLY+1))
    else $error("frame delay not constant");
  pass_through_a: assert property (!mod && st.vld |=> out_beat.data == $past(st.data))
    else $error("ignored frame was altered");
  rsv_write_a: assert property (mod && !dir_egress && st.vld && rel_o == `OTS_OFF_RSV
    |=> out_beat.data == {2'b00, $past(stamp_r.ns[29:24])})
    else $error("reserved byte not stamp");
  udp_zero_a: assert property (mod && encap_v4 && st.vld && rel_o == `OTS_OFF_UDP_HI
    |=> out_beat.data == 8'h00 ##1 out_beat.data == 8'h00)
    else $error("udp checksum not zeroed");
  fifo_push_a: assert property (push && !full |=> ts_level == $past(ts_level) + 1'b1
    || ts_rd_vld)
    else $error("saved set not stored");
  read_answer_a: assert property (ts_rd && !ts_empty
    |=> ts_rd_vld ##1 (!ts_rd_vld || $past(ts_rd)))
    else $error("fifo read not answered");
  time_range_a: assert property (local_time.ns < `OTS_NS_PER_SEC)
    else $error("ns counter out of range");
  unmatched_a: assert property (in_beat.vld && rel_i == `OTS_OFF_DOM && !in_beat.sof
    && in_beat.data != domain_cfg |=> act_r == ots_pkg::ignore_action && !stamp_vld_r)
    else $error("unmatched frame kept action");
  sync_seen_c: cover property (mod && msg_r == `OTS_MSG_SYNC && out_beat.eof);
  save_seen_c: cover property (push && !full);
  bad_fcs_c: cover property (mod && fcs_bad_r && tail_hit);
endmodule
`default_nettype wire

// File: verif/ots_line_model.sv
// line-side coding model that sends clear-text frames into the pipeline
`timescale 1ns/10ps
`default_nettype none
module ots_line_model (
  input wire logic clk_sys,
  output var ots_pkg::ots_beat_s tx_beat
);
  // ----------------------------------------
  // frame source
  // ----------------------------------------
  logic [7:0] frm [64]; // frame bytes, loaded by the bench
  initial tx_beat = '0;
  // bytes back to back from sof to eof, then an idle gap of the caller's choosing
  task automatic send(input int len, input int gap);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_sys);
      tx_beat <= '{vld: 1'b1, sof: (i == 0), eof: (i == len - 1), data: frm[i]};
    end
    @(posedge clk_sys);
    // released line shows the inverse of its last byte, never a stale copy
    tx_beat <= '{vld: 1'b0, sof: 1'b0, eof: 1'b0, data: ~frm[len - 1]};
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: verif/test_ots_pipe.sv
// self-checking bench for the one-step time stamp pipeline
`include "ots_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module test_ots_pipe;
  // ----------------------------------------
  // setup and signals
  // ----------------------------------------
  localparam int DLY = 12; // shortest legal delay line
  localparam int LEN = 64; // frame length with fcs
  localparam int PO = 14; // ptp header start
  localparam logic [3:0] MSGS [3] = '{4'h0, 4'h1, 4'h9}; // sync, delay_req, delay_resp
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic dir_egress = 1'b0;
  logic encap_v4 = 1'b0;
  logic res_mode = 1'b0;
  logic [7:0] domain_cfg = 8'h00;
  logic [29:0] lat_corr = 30'h0;
  logic [63:0] asym = 64'h0;
  logic [95:0] id_off = 96'h0;
  logic ts_rd = 1'b0;
  ots_pkg::ots_beat_s in_beat, out_beat;
  ots_pkg::ots_time_s local_time, ts_rd_stamp, sof_time;
  logic ts_rd_vld, ts_empty, ts_drop;
  logic [127:0] ts_rd_id;
  logic [3:0] ts_level;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int sof_cyc = 0;
  int lat_seen = 0;
  logic [7:0] exp_f [LEN]; // expected frame
  logic [7:0] got_q [$]; // bytes seen at the output

  ots_line_model u_ots_line_model (.clk_sys(clk_sys), .tx_beat(in_beat));
  ots_pipe #(.DLY(DLY), .TSF_DEPTH(8)) u_ots_pipe (.clk_sys(clk_sys), .reset(reset),
    .dir_egress(dir_egress), .res_mode(res_mode), .domain_cfg(domain_cfg), .ptp_off(8'h0E),
    .encap_v4(encap_v4), .encap_v6(1'b0), .pad_off(8'h2C), .lat_corr(lat_corr), .asym(asym),
    .id_off(id_off), .in_beat(in_beat), .out_beat(out_beat), .local_time(local_time),
    .ts_rd(ts_rd), .ts_rd_vld(ts_rd_vld), .ts_rd_id(ts_rd_id), .ts_rd_stamp(ts_rd_stamp),
    .ts_empty(ts_empty), .ts_level(ts_level), .ts_drop(ts_drop));

  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------
  // monitor: sof time, latency, output bytes
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (in_beat.vld && in_beat.sof) begin
      sof_time <= local_time;
      sof_cyc <= cyc;
    end
    if (out_beat.vld === 1'b1) begin
      got_q.push_back(out_beat.data);
    end
    if (out_beat.vld === 1'b1 && out_beat.sof === 1'b1) begin
      lat_seen <= cyc - sof_cyc;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // reflected crc-32 register over the first n expected bytes
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = `OTS_CRC_SEED;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, exp_f[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ `OTS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  // big-endian field write into the expected frame
  task automatic put(input int at, input int n, input logic [79:0] v);
    for (int i = 0; i < n; i++) exp_f[at + i] = v[8 * (n - 1 - i) +: 8];
  endtask
  function automatic logic [63:0] get8(input int at);
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < 8; i++) v = {v[55:0], exp_f[at + i]};
    return v;
  endfunction
  task automatic put_fcs(input logic [31:0] c);
    for (int i = 0; i < 4; i++) exp_f[LEN - 4 + i] = c[8 * i +: 8];
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // one frame: build, send, predict, compare
  // ----------------------------------------
  task automatic run_frame(input logic egr, input logic [3:0] msg, input logic dom_ok,
                           input logic bad);
    logic match;
    logic save;
    logic [7:0] dom;
    logic [29:0] ns;
    logic [30:0] t;
    logic [31:0] sec;
    logic [95:0] ido;
    logic [127:0] id;
    int k;
    logic rm;
    logic [29:0] r;
    dom = 8'($urandom);
    rm = 1'($urandom);
    for (int i = 0; i < 16; i++) ido[6 * i +: 6] = 6'(20 + $urandom_range(13));
    @(posedge clk_sys);
    dir_egress <= egr;
    encap_v4 <= 1'($urandom);
    domain_cfg <= dom;
    lat_corr <= 30'($urandom_range(999999999));
    asym <= {$urandom, $urandom};
    id_off <= ido;
    res_mode <= rm;
    for (int i = 0; i < LEN - 4; i++) exp_f[i] = 8'($urandom);
    exp_f[PO] = {4'h0, msg};
    exp_f[PO + 4] = dom_ok ? dom : ~dom;
    // software-built delay_req: cf zero, sub-second stamp in reserved bytes
    if (rm && egr && msg == 4'h1) begin
      put(PO + 8, 8, 80'h0);
      put(PO + 16, 4, {50'h0, 30'($urandom_range(999999999))});
    end
    put_fcs(bad ? crc_of(LEN - 4) : ~crc_of(LEN - 4));
    for (int i = 0; i < 16; i++) id[127 - 8 * i -: 8] = exp_f[PO + ido[6 * i +: 6]];
    for (int i = 0; i < LEN; i++) u_ots_line_model.frm[i] = exp_f[i];
    got_q.delete();
    u_ots_line_model.send(LEN, DLY + $urandom_range(8));
    match = dom_ok && (msg < 4'h2);
    save = match && egr && (msg == 4'h1);
    if (match && !egr) begin
      ns = (sof_time.ns >= lat_corr) ? sof_time.ns - lat_corr
                                     : sof_time.ns + `OTS_NS_PER_SEC - lat_corr;
      put(PO + 16, 4, {2'b0, ns});
      if (msg == 4'h0) put(PO + 8, 8, get8(PO + 8) + asym);
    end
    t = {1'b0, sof_time.ns} + {1'b0, lat_corr};
    sec = sof_time.sec;
    if (t >= {1'b0, `OTS_NS_PER_SEC}) begin
      t = t - {1'b0, `OTS_NS_PER_SEC};
      sec = sec + 32'h1;
    end
    ns = t[29:0];
    if (match && egr && rm && msg == 4'h1) begin
      // residence from software sub-second to departure, no origin write
      r = {exp_f[PO + 16][5:0], exp_f[PO + 17], exp_f[PO + 18], exp_f[PO + 19]};
      r = (ns >= r) ? ns - r : ns + `OTS_NS_PER_SEC - r;
      put(PO + 8, 8, get8(PO + 8) + asym + {18'h0, r, 16'h0});
    end else if (match && egr) begin
      put(PO + 34, 10, {16'h0, sec, 2'b0, ns});
      if (msg == 4'h1) put(PO + 8, 8, get8(PO + 8) + asym);
    end
    if (match && encap_v4) put(PO - 2, 2, 16'h0);
    if (match) put_fcs(bad ? crc_of(LEN - 4) : ~crc_of(LEN - 4));
    for (k = 0; k < 40 && got_q.size() < LEN; k++) @(posedge clk_sys);
    if (got_q.size() < LEN) begin
      bad_count++;
      $display("mismatch output frame expected %0d bytes seen %0d", LEN, got_q.size());
      finish_test;
    end
    for (int i = 0; i < LEN; i++) check("frame byte", exp_f[i], got_q[i]);
    check("latency", DLY + 1, lat_seen);
    check("fifo level", {3'h0, save}, ts_level);
    check("drop", 0, ts_drop);
    if (save) begin
      @(posedge clk_sys);
      ts_rd <= 1'b1;
      @(posedge clk_sys);
      ts_rd <= 1'b0;
      #1;
      check("read valid", 1, ts_rd_vld);
      check("read id", id, ts_rd_id);
      check("read stamp", {sec, ns}, ts_rd_stamp);
      check("empty after read", 1, ts_empty);
    end
    $display("test egress %0d msg %0d domain %0d badfcs %0d done", egr, msg, dom_ok, bad);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int seed;
    logic [29:0] t0;
    seed = $urandom(84);
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    t0 = local_time.ns;
    repeat (4) @(posedge clk_sys);
    #1;
    check("time step", t0 + 30'h64, local_time.ns);
    // read while empty is ignored
    @(posedge clk_sys);
    ts_rd <= 1'b1;
    @(posedge clk_sys);
    ts_rd <= 1'b0;
    #1;
    check("empty read", 0, ts_rd_vld);
    // corner cases, then random traffic
    run_frame(1'b0, 4'h0, 1'b1, 1'b0);
    run_frame(1'b0, 4'h1, 1'b1, 1'b1);
    run_frame(1'b0, 4'h9, 1'b1, 1'b0);
    run_frame(1'b0, 4'h0, 1'b0, 1'b1);
    run_frame(1'b1, 4'h0, 1'b1, 1'b0);
    run_frame(1'b1, 4'h1, 1'b1, 1'b1);
    for (int i = 0; i < 24; i++) begin
      run_frame(1'($urandom), MSGS[$urandom_range(2)], 1'($urandom), 1'($urandom));
    end
    finish_test;
  end
endmodule
`default_nettype wire
